/* File: src/blsbu_defines.vh */
// Opcode, state and width constants for the byte logic/shift/bit unit
`ifndef BLSBU_DEFINES_VH
`define BLSBU_DEFINES_VH

`define BLSBU_OP_W            5
`define BLSBU_OP_AND          5'h00
`define BLSBU_OP_OR           5'h01
`define BLSBU_OP_XOR          5'h02
`define BLSBU_OP_NOT          5'h03
`define BLSBU_ARITH_SHIFT_LEFT         5'h04
`define BLSBU_ARITH_SHIFT_RIGHT        5'h05
`define BLSBU_LOGIC_SHIFT_LEFT         5'h06
`define BLSBU_LOGIC_SHIFT_RIGHT        5'h07
`define BLSBU_ROTATE_LEFT              5'h08
`define BLSBU_ROTATE_RIGHT             5'h09
`define BLSBU_ROTATE_LEFT_VIA_CARRY    5'h0a
`define BLSBU_ROTATE_RIGHT_VIA_CARRY   5'h0b
`define BLSBU_BIT_SET_OP               5'h0c
`define BLSBU_BIT_CLEAR_OP             5'h0d
`define BLSBU_BIT_INVERT_OP            5'h0e
`define BLSBU_BIT_TEST_OP              5'h0f
`define BLSBU_CARRY_AND_BIT            5'h10
`define BLSBU_CARRY_AND_INV_BIT        5'h11
`define BLSBU_CARRY_OR_BIT             5'h12
`define BLSBU_CARRY_OR_INV_BIT         5'h13
`define BLSBU_CARRY_XOR_BIT            5'h14
`define BLSBU_CARRY_XOR_INV_BIT        5'h15
`define BLSBU_BIT_TO_CARRY             5'h16
`define BLSBU_INV_BIT_TO_CARRY         5'h17
`define BLSBU_CARRY_TO_BIT             5'h18
`define BLSBU_INV_CARRY_TO_BIT         5'h19

`define BLSBU_ST_W            2
`define BLSBU_ST_IDLE         2'h0
`define BLSBU_ST_READ         2'h1
`define BLSBU_ST_WRITE        2'h2

`define BLSBU_WO_READ_VALUE   8'hff
`define BLSBU_ADDR_W          16

`endif

/* File: src/blsbu_unit.v */
// Byte logic, shift, rotate and bit-manipulation datapath
`include "blsbu_defines.vh"

module blsbu_unit
(
  input  wire                      ref_clk,
  input  wire                      srst,
  input  wire                      clk_en,
  input  wire                      start,
  input  wire [`BLSBU_OP_W-1:0]    opcode,
  input  wire                      use_imm,
  input  wire                      mem_target,
  input  wire [`BLSBU_ADDR_W-1:0]  mem_addr,
  input  wire [7:0]                dest_data,
  input  wire [7:0]                source_register,
  input  wire [7:0]                imm_data,
  input  wire [2:0]                imm_bit,
  input  wire                      carry_in,
  input  wire                      zero_in,
  input  wire [7:0]                mem_rdata,
  input  wire                      mem_write_only,
  input  wire                      mem_ack,
  output wire                      busy,
  output reg                       done,
  output reg                       illegal_op,
  output reg  [7:0]                result,
  output reg                       result_we,
  output reg                       carry_out,
  output reg                       zero_out,
  output reg                       mem_rd,
  output reg                       mem_wr,
  output reg  [`BLSBU_ADDR_W-1:0]  mem_addr_out,
  output reg  [7:0]                mem_wdata
);

  reg [`BLSBU_ST_W-1:0]    state_reg;
  reg [`BLSBU_OP_W-1:0]    op_reg;
  reg [2:0]                bit_reg;
  reg                      carry_reg;
  reg                      zero_reg;

  reg [7:0]  operand;
  reg [2:0]  bit_idx;
  reg        imm_only;
  reg        is_bit_op;
  reg        is_rmw;
  reg [7:0]  calc_val;
  reg        calc_c;
  reg        calc_z;
  reg        calc_we;
  reg        calc_illegal;
  reg [7:0]  onehot;
  reg        sel_bit;
  reg [7:0]  rmw_byte;
  reg [7:0]  rmw_val;

  assign busy = (state_reg != `BLSBU_ST_IDLE);

  // Classify the opcode and pick the bit index source
  always @*
  begin
    is_bit_op = (opcode >= `BLSBU_BIT_SET_OP) &&
                (opcode <= `BLSBU_INV_CARRY_TO_BIT);
    is_rmw    = (opcode == `BLSBU_BIT_SET_OP) ||
                (opcode == `BLSBU_BIT_CLEAR_OP) ||
                (opcode == `BLSBU_BIT_INVERT_OP) ||
                (opcode == `BLSBU_CARRY_TO_BIT) ||
                (opcode == `BLSBU_INV_CARRY_TO_BIT);
    imm_only  = (opcode == `BLSBU_CARRY_AND_INV_BIT) ||
                (opcode == `BLSBU_CARRY_OR_INV_BIT) ||
                (opcode == `BLSBU_CARRY_XOR_INV_BIT) ||
                (opcode == `BLSBU_INV_BIT_TO_CARRY) ||
                (opcode == `BLSBU_INV_CARRY_TO_BIT);
    // index immediate or register low bits
    bit_idx   = use_imm ? imm_bit : source_register[2:0];
    operand   = use_imm ? imm_data : source_register;
  end

  // Compute one operation on a byte; shared by register and memory paths
  // byte-wide operands only
  task blsbu_compute;
    input [`BLSBU_OP_W-1:0] op;
    input [7:0]             d;
    input [7:0]             s;
    input [2:0]             idx;
    input                   c;
    input                   z;
    reg   [7:0]             mask;
    reg                     b;
    begin
      mask    = 8'h01 << idx;
      b       = |(d & mask);
      calc_val = d;
      calc_c   = c;
      calc_z   = z;
      calc_we  = 1'b1;
      case (op)
        `BLSBU_OP_AND:   calc_val = d & s;
        `BLSBU_OP_OR:    calc_val = d | s;
        `BLSBU_OP_XOR:   calc_val = d ^ s;
        `BLSBU_OP_NOT:   calc_val = ~d;
        `BLSBU_ARITH_SHIFT_LEFT:
        begin
          calc_val = {d[6:0], 1'b0};
          calc_c   = d[7];
        end
        `BLSBU_ARITH_SHIFT_RIGHT:
        begin
          calc_val = {d[7], d[7:1]};
          calc_c   = d[0];
        end
        `BLSBU_LOGIC_SHIFT_LEFT:
        begin
          calc_val = {d[6:0], 1'b0};
          calc_c   = d[7];
        end
        `BLSBU_LOGIC_SHIFT_RIGHT:
        begin
          calc_val = {1'b0, d[7:1]};
          calc_c   = d[0];
        end
        `BLSBU_ROTATE_LEFT:
        begin
          calc_val = {d[6:0], d[7]};
          calc_c   = d[7];
        end
        `BLSBU_ROTATE_RIGHT:
        begin
          calc_val = {d[0], d[7:1]};
          calc_c   = d[0];
        end
        `BLSBU_ROTATE_LEFT_VIA_CARRY:
        begin
          calc_val = {d[6:0], c};
          calc_c   = d[7];
        end
        `BLSBU_ROTATE_RIGHT_VIA_CARRY:
        begin
          calc_val = {c, d[7:1]};
          calc_c   = d[0];
        end
        `BLSBU_BIT_SET_OP:     calc_val = d | mask;
        `BLSBU_BIT_CLEAR_OP:   calc_val = d & ~mask;
        `BLSBU_BIT_INVERT_OP:  calc_val = d ^ mask;
        `BLSBU_BIT_TEST_OP:
        begin
          calc_z  = ~b;
          calc_we = 1'b0;
        end
        `BLSBU_CARRY_AND_BIT:
        begin
          calc_c  = c & b;
          calc_we = 1'b0;
        end
        `BLSBU_CARRY_AND_INV_BIT:
        begin
          calc_c  = c & ~b;
          calc_we = 1'b0;
        end
        `BLSBU_CARRY_OR_BIT:
        begin
          calc_c  = c | b;
          calc_we = 1'b0;
        end
        `BLSBU_CARRY_OR_INV_BIT:
        begin
          calc_c  = c | ~b;
          calc_we = 1'b0;
        end
        `BLSBU_CARRY_XOR_BIT:
        begin
          calc_c  = c ^ b;
          calc_we = 1'b0;
        end
        `BLSBU_CARRY_XOR_INV_BIT:
        begin
          calc_c  = c ^ ~b;
          calc_we = 1'b0;
        end
        `BLSBU_BIT_TO_CARRY:
        begin
          calc_c  = b;
          calc_we = 1'b0;
        end
        `BLSBU_INV_BIT_TO_CARRY:
        begin
          calc_c  = ~b;
          calc_we = 1'b0;
        end
        `BLSBU_CARRY_TO_BIT:
          calc_val = c ? (d | mask) : (d & ~mask);
        `BLSBU_INV_CARRY_TO_BIT:
          calc_val = c ? (d & ~mask) : (d | mask);
        default:         calc_we  = 1'b0;
      endcase
    end
  endtask

  // Register- and memory-path evaluation plus legality check
  always @*
  begin
    onehot   = 8'h00;
    sel_bit  = 1'b0;
    calc_val = 8'h00;
    calc_c   = 1'b0;
    calc_z   = 1'b0;
    calc_we  = 1'b0;
    rmw_byte = 8'h00;
    rmw_val  = 8'h00;
    calc_illegal = (opcode > `BLSBU_INV_CARRY_TO_BIT) ||
                   (imm_only && !use_imm) ||
                   (mem_target && !is_bit_op);
    if (state_reg == `BLSBU_ST_READ)
    begin
      // write-only target reads as all ones
      rmw_byte = mem_write_only ? `BLSBU_WO_READ_VALUE : mem_rdata;
      blsbu_compute(op_reg, rmw_byte, 8'h00, bit_reg, carry_reg, zero_reg);
      rmw_val  = calc_val;
    end
    else
    begin
      blsbu_compute(opcode, dest_data, operand, bit_idx, carry_in, zero_in);
    end
    onehot  = 8'h01 << bit_idx;
    sel_bit = |(dest_data & onehot);
  end

  // Sequencer: one cycle for register ops, read/modify/write for memory bit writes, read only for memory tests
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_reg    <= `BLSBU_ST_IDLE;
      op_reg       <= `BLSBU_OP_AND;
      bit_reg      <= 3'h0;
      carry_reg    <= 1'b0;
      zero_reg     <= 1'b0;
      done         <= 1'b0;
      illegal_op   <= 1'b0;
      result       <= 8'h00;
      result_we    <= 1'b0;
      carry_out    <= 1'b0;
      zero_out     <= 1'b0;
      mem_rd       <= 1'b0;
      mem_wr       <= 1'b0;
      mem_addr_out <= {`BLSBU_ADDR_W{1'b0}};
      mem_wdata    <= 8'h00;
    end
    else if (clk_en)
    begin
      done       <= 1'b0;
      result_we  <= 1'b0;
      illegal_op <= 1'b0;
      case (state_reg)
        `BLSBU_ST_IDLE:
        begin
          if (start && calc_illegal)
          begin
            illegal_op <= 1'b1;
            done       <= 1'b1;
          end
          else if (start && mem_target)
          begin
            op_reg       <= opcode;
            bit_reg      <= bit_idx;
            carry_reg    <= carry_in;
            zero_reg     <= zero_in;
            mem_addr_out <= mem_addr;
            mem_rd       <= 1'b1;
            state_reg    <= `BLSBU_ST_READ;
          end
          else if (start)
          begin
            result    <= calc_val;
            result_we <= calc_we;
            carry_out <= calc_c;
            zero_out  <= calc_z;
            done      <= 1'b1;
          end
        end
        `BLSBU_ST_READ:
        begin
          if (mem_ack)
          begin
            mem_rd    <= 1'b0;
            carry_out <= calc_c;
            zero_out  <= calc_z;
            if (is_rmw_op(op_reg))
            begin
              // steps two and three, modify and write
              mem_wdata <= rmw_val;
              mem_wr    <= 1'b1;
              state_reg <= `BLSBU_ST_WRITE;
            end
            else
            begin
              done      <= 1'b1;
              state_reg <= `BLSBU_ST_IDLE;
            end
          end
        end
        `BLSBU_ST_WRITE:
        begin
          // Same address held from the read phase
          if (mem_ack)
          begin
            mem_wr    <= 1'b0;
            done      <= 1'b1;
            state_reg <= `BLSBU_ST_IDLE;
          end
        end
        default:
          state_reg <= `BLSBU_ST_IDLE;
      endcase
    end
  end

  // True for operations that write the whole byte back
  function is_rmw_op;
    input [`BLSBU_OP_W-1:0] op;
    begin
      is_rmw_op = (op == `BLSBU_BIT_SET_OP) ||
                  (op == `BLSBU_BIT_CLEAR_OP) ||
                  (op == `BLSBU_BIT_INVERT_OP) ||
                  (op == `BLSBU_CARRY_TO_BIT) ||
                  (op == `BLSBU_INV_CARRY_TO_BIT);
    end
  endfunction

endmodule

/* File: tb/blsbu_unit_sva.sv */
// Concurrent checks on the byte logic, shift and bit unit ports
`include "blsbu_defines.vh"
module blsbu_sva
(
  input wire       ref_clk,
  input wire       srst,
  input wire       clk_en,
  input wire       start,
  input wire [4:0] opcode,
  input wire       use_imm,
  input wire       mem_target,
  input wire [2:0] imm_bit,
  input wire       mem_write_only,
  input wire       mem_ack,
  input wire       busy,
  input wire       done,
  input wire       illegal_op,
  input wire       result_we,
  input wire       mem_rd,
  input wire       mem_wr,
  input wire [7:0] mem_wdata
);
  // Request decode; bench holds opcode steady for a whole operation
  wire go = start && !busy && clk_en;
  wire inv = opcode >= 5'h11 && opcode <= 5'h19 && opcode[0];
  wire bit_op = opcode >= 5'h0c && opcode <= 5'h19;
  wire mem_ok = mem_target && bit_op && !(inv && !use_imm);
  wire rmw = (opcode >= 5'h0c && opcode <= 5'h0e) || opcode >= 5'h18;
  wire rd_fin = mem_rd && mem_ack && clk_en;
  wire wr_fin = mem_wr && mem_ack && clk_en;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  sequence to_write;
    !mem_rd && mem_wr && !done;
  endsequence
  sequence to_done;
    done && !mem_wr && !mem_rd;
  endsequence
  go_reg_a: assert property (go && !mem_ok |=> done)
    else $error("register op late");
  go_mem_a: assert property (go && mem_ok |=> mem_rd && busy && !done)
    else $error("memory read not started");
  inv_refuse_a: assert property (go && inv && !use_imm |=> illegal_op)
    else $error("register index taken for inverted op");
  illegal_done_a: assert property (illegal_op |-> done && !result_we)
    else $error("refusal changed state");
  rd_hold_a: assert property (mem_rd && !mem_ack |=> mem_rd && busy)
    else $error("read dropped early");
  rmw_write_a: assert property (rd_fin && rmw |=> to_write)
    else $error("no write back after read");
  rd_only_a: assert property (rd_fin && !rmw |=> to_done)
    else $error("read only op wrote memory");
  wr_done_a: assert property (wr_fin |=> to_done)
    else $error("write not finished");
  wo_fill_a: assert property (rd_fin && mem_write_only && use_imm &&
    opcode == `BLSBU_BIT_CLEAR_OP |=> mem_wdata == ~(8'h01 << imm_bit))
    else $error("write only byte not read as ones");
  flag_only_a: assert property (go && !mem_target && opcode >= 5'h0f &&
    opcode <= 5'h17 |=> done && !result_we)
    else $error("flag op wrote register");
endmodule

bind blsbu_unit blsbu_sva u_sva (.ref_clk(ref_clk), .srst(srst),
  .clk_en(clk_en), .start(start), .opcode(opcode), .use_imm(use_imm),
  .mem_target(mem_target), .imm_bit(imm_bit), .mem_ack(mem_ack),
  .mem_write_only(mem_write_only), .busy(busy), .done(done),
  .illegal_op(illegal_op), .result_we(result_we), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .mem_wdata(mem_wdata));

/* File: tb/test_byte_logic_shift_bit_unit.sv */
// Self-checking bench for the byte logic, shift and bit unit
`include "blsbu_defines.vh"
module test_byte_logic_shift_bit_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = '0, srst = '1, clk_en = '1, start = '0;
  logic        use_imm = '0, mem_target = '0, mem_write_only = '0;
  logic        carry_in = '0, zero_in = '0, mem_ack = '0;
  logic [4:0]  opcode = '0;
  logic [15:0] mem_addr = 16'h0040;
  logic [7:0]  dest_data = '0, source_register = '0, imm_data = '0;
  logic [7:0]  mem_rdata = '0, wd;
  logic [2:0]  imm_bit = '0;
  wire         busy, done, illegal_op, result_we, carry_out, zero_out;
  wire         mem_rd, mem_wr;
  wire [15:0]  mem_addr_out;
  wire [7:0]   result, mem_wdata;
  integer      mismatches = 0, total_checks = 0, nw;

  blsbu_unit DUT (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
    .start(start), .opcode(opcode), .use_imm(use_imm),
    .mem_target(mem_target), .mem_addr(mem_addr), .dest_data(dest_data),
    .source_register(source_register), .imm_data(imm_data),
    .imm_bit(imm_bit), .carry_in(carry_in), .zero_in(zero_in),
    .mem_rdata(mem_rdata), .mem_write_only(mem_write_only),
    .mem_ack(mem_ack), .busy(busy), .done(done), .illegal_op(illegal_op),
    .result(result), .result_we(result_we), .carry_out(carry_out),
    .zero_out(zero_out), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr_out(mem_addr_out), .mem_wdata(mem_wdata));

  // Free running 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  task chk(input string nm, input [7:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One operation; memory answers after a stall, data scrambled off ack
  task op(input [4:0] o, input mt, wo, ui, input [7:0] d, s, im,
          input [2:0] ib, input c, input [7:0] rd);
    integer n, w;
    logic   a;
    @(posedge ref_clk);
    opcode <= o;
    mem_target <= mt;
    mem_write_only <= wo;
    use_imm <= ui;
    dest_data <= d;
    source_register <= s;
    imm_data <= im;
    imm_bit <= ib;
    carry_in <= c;
    start <= '1;
    @(posedge ref_clk);
    start <= '0;
    nw = 0;
    w = 0;
    for (n = 0; n < 40; n++)
    begin
      #1;
      if (done === 1'h1)
        break;
      w = (mem_rd === 1'h1 || mem_wr === 1'h1) ? w + 1 : 0;
      a = (w == 3);
      if (a)
        w = 0;
      if (a && mem_wr === 1'h1)
      begin
        nw++;
        wd = mem_wdata;
      end
      @(posedge ref_clk);
      mem_ack <= a;
      mem_rdata <= a ? rd : ~rd;
    end
    chk("done", done, 8'h01);
  endtask

  // Register operand; index x in register, its inverse as immediate
  task rop(input [4:0] o, input [7:0] d, input ui, input [2:0] x, input c);
    op(o, '0, '0, ui, d, {5'h15, x}, 8'h00, ~x, c, 8'h00);
  endtask

  task mop(input [4:0] o, input wo, ui, input [2:0] x, input c);
    op(o, '1, wo, ui, 8'h00, {5'h15, x}, 8'h00, ~x, c, 8'h3f);
  endtask

  task t_logic;
    integer     i, u;
    logic [7:0] b, e;
    for (i = 0; i < 8; i++)
    begin
      u = i % 2;
      b = u ? 8'hc3 : 8'h3c;
      e = i < 2 ? 8'h5a & b : i < 4 ? 8'h5a | b : i < 6 ? 8'h5a ^ b : 8'ha5;
      op(i[5:1], '0, '0, u[0], 8'h5a, 8'h3c, 8'hc3, '0, '0, 8'h00);
      chk("logic", result, e);
      chk("logic_we", result_we, 8'h01);
    end
    $display("logic test ended");
  endtask

  task t_shift;
    integer     i;
    logic [7:0] d, e;
    logic       c, ec;
    for (i = 0; i < 16; i++)
    begin
      d = i[3] ? 8'h68 : 8'h97;
      c = i[3];
      case (i[2:0])
        0, 2: {ec, e} = {d, 1'h0};
        1: {e, ec} = {d[7], d};
        3: {e, ec} = {1'h0, d};
        4: {ec, e} = {d, d[7]};
        5: {e, ec} = {d[0], d};
        6: {ec, e} = {d, c};
        default: {e, ec} = {c, d};
      endcase
      rop(`BLSBU_ARITH_SHIFT_LEFT + i[2:0], d, '0, 3'h0, c);
      chk("shift", result, e);
      chk("shift_c", carry_out, ec);
    end
    $display("shift test ended");
  endtask

  task t_bits;
    integer     j;
    logic [7:0] m;
    logic [2:0] x;
    logic       b, bb, e;
    for (j = 0; j < 8; j++)
    begin
      m = 8'h01 << j;
      x = j[0] ? ~j[2:0] : j[2:0];
      rop(`BLSBU_BIT_SET_OP, 8'h00, j[0], x, '0);
      chk("set", result, m);
      rop(`BLSBU_BIT_CLEAR_OP, 8'hff, j[0], x, '0);
      chk("clear", result, ~m);
      rop(`BLSBU_BIT_INVERT_OP, 8'h5a, j[0], x, '0);
      chk("invert", result, 8'h5a ^ m);
      rop(`BLSBU_BIT_TEST_OP, 8'h5a, j[0], x, '0);
      chk("test_z", zero_out, ~|(8'h5a & m));
    end
    // Bit 1 of 8'h5a is one, bit 2 is zero
    for (j = 0; j < 32; j++)
    begin
      b = j[3];
      bb = j[0] ? ~b : b;
      case (j[2:1])
        0: e = j[4] & bb;
        1: e = j[4] | bb;
        2: e = j[4] ^ bb;
        default: e = bb;
      endcase
      rop(`BLSBU_CARRY_AND_BIT + j[2:0], 8'h5a, '1, b ? 3'h6 : 3'h5, j[4]);
      chk("carry_op", carry_out, e);
      chk("carry_we", result_we, '0);
    end
    for (j = 0; j < 2; j++)
    begin
      rop(`BLSBU_CARRY_TO_BIT, 8'h5a, '1, 3'h4, j[0]);
      chk("store", result, {4'h5, j[0], 3'h2});
      rop(`BLSBU_INV_CARRY_TO_BIT, 8'h5a, '1, 3'h4, j[0]);
      chk("inv_store", result, {4'h5, ~j[0], 3'h2});
    end
    $display("bit test ended");
  endtask

  task t_refuse;
    integer j;
    rop(`BLSBU_BIT_TO_CARRY, 8'h01, '1, 3'h7, '0);
    chk("load", carry_out, 8'h01);
    for (j = 0; j < 5; j++)
    begin
      rop(`BLSBU_CARRY_AND_INV_BIT + {j[3:0], 1'h0}, 8'h00, '0, 3'h0, '0);
      chk("inv_reg", illegal_op, 8'h01);
      chk("inv_c", carry_out, 8'h01);
    end
    $display("refusal test ended");
  endtask

  task t_mem;
    mop(`BLSBU_BIT_CLEAR_OP, '1, '1, 3'h7, '0);
    chk("wo_data", wd, 8'hfe);
    chk("rmw_addr", mem_addr_out[7:0], 8'h40);
    chk("rmw_wr", nw[7:0], 8'h01);
    mop(`BLSBU_BIT_SET_OP, '0, '0, 3'h7, '0);
    chk("mem_set", wd, 8'hbf);
    mop(`BLSBU_BIT_INVERT_OP, '0, '1, 3'h7, '0);
    chk("mem_inv", wd, 8'h3e);
    mop(`BLSBU_CARRY_TO_BIT, '0, '1, 3'h1, '1);
    chk("mem_st", wd, 8'h7f);
    mop(`BLSBU_INV_CARRY_TO_BIT, '0, '1, 3'h7, '1);
    chk("mem_ist", wd, 8'h3e);
    mop(`BLSBU_BIT_TEST_OP, '0, '1, 3'h1, '0);
    chk("mem_tst", zero_out, 8'h01);
    chk("tst_nowr", nw[7:0], 8'h00);
    $display("memory test ended");
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Reset for 20 cycles, then the scenarios in turn
  initial
  begin
    repeat (20) @(posedge ref_clk);
    srst <= '0;
    t_logic;
    t_shift;
    t_bits;
    t_refuse;
    t_mem;
    complete_run;
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    #500000;
    mismatches++;
    complete_run;
  end
endmodule
